/* File: include/csa_pkg.sv */
// Constants for the charge status and alarm evaluator.
// Assumes a 50 MHz clock and 16-bit measurement words.
package csa_pkg;
  localparam longint unsigned CLK_HZ = 64'd50_000_000;
  localparam longint unsigned TAPER_S = 64'd40;
  localparam longint unsigned TAPER_CYC = CLK_HZ * TAPER_S;
  // Current LSB 0.5 mA, temperature LSB 0.1 C, voltage 1 mV
  localparam logic [15:0] TAPER_MIN_I = 16'h002D;
  localparam logic [15:0] AVG_CLR_I = 16'h0200;
  localparam logic [15:0] OT_FLOOR_T = 16'h01AE;
  localparam logic [15:0] DSG_CLR_MAH = 16'h0002;
  localparam logic [15:0] FD_CLR_PCT = 16'h0014;
  localparam logic [15:0] LTFH_RST = 16'h001E;
  localparam logic [15:0] PCT_FULL = 16'h0064;
  // Control word indices, byte address is four times
  localparam logic [5:0] W_CTRL = 6'h00;
  localparam logic [5:0] W_STAT = 6'h01;
  localparam logic [5:0] W_IRQ = 6'h02;
  localparam logic [5:0] W_MASK = 6'h03;
  localparam logic [5:0] W_CCREQ = 6'h04;
  localparam logic [5:0] W_RMLD = 6'h05;
  localparam logic [5:0] W_CFG0 = 6'h10;
  localparam int NCFG = 38;
  localparam int CTRL_SYNC = 0;
  localparam int CTRL_UPD = 1;
  // Threshold and measurement table indices
  localparam int C_VOLT = 0;
  localparam int C_CURR = 1;
  localparam int C_AVGI = 2;
  localparam int C_TEMP = 3;
  localparam int C_CELL = 4;
  localparam int C_RM = 8;
  localparam int C_FCC = 9;
  localparam int C_RELATIVE_CHARGE_PCT = 10;
  localparam int C_AVG_TIME_TO_EMPTY = 11;
  localparam int C_OVCHG = 12;
  localparam int C_DSGMAH = 13;
  localparam int C_CHGV = 14;
  localparam int C_FASTI = 15;
  localparam int C_MAINTI = 16;
  localparam int C_PREI = 17;
  localparam int C_TAPQV = 18;
  localparam int C_TAPI = 19;
  localparam int C_OCM = 20;
  localparam int C_OVM = 21;
  localparam int C_CELLOV = 22;
  localparam int C_CELLOVR = 23;
  localparam int C_MAXT = 24;
  localparam int C_THYS = 25;
  localparam int C_LTF = 26;
  localparam int C_LTFH = 27;
  localparam int C_OLI = 28;
  localparam int C_CELLUV = 29;
  localparam int C_CELLUVR = 30;
  localparam int C_TERMV = 31;
  localparam int C_BLOW = 32;
  localparam int C_FCCLR = 33;
  localparam int C_TPCT = 34;
  localparam int C_RCA = 35;
  localparam int C_RTA = 36;
  localparam int C_MAXOC = 37;
  // Status bit positions
  localparam int S_TCA = 0;
  localparam int S_OTA = 1;
  localparam int S_OCA = 2;
  localparam int S_TDA = 3;
  localparam int S_FC = 4;
  localparam int S_FD = 5;
  localparam int S_RCA = 6;
  localparam int S_RTA = 7;
  localparam int S_CFET = 8;
  localparam int S_DFET = 9;
  localparam int NST = 10;
  typedef enum logic [1:0] {
    CSA_ZERO = 2'b00,
    CSA_PRE = 2'b01,
    CSA_MAINT = 2'b10,
    CSA_FAST = 2'b11
  } csa_rate_t;
endpackage

/* File: src/csa_charge_status.sv */
// Charge state evaluator with alarm flags and charge request.
// Assumes firmware writes measurements, then pulses the update bit.
//
// The placing of the registers and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////////////////////////////////
// Contract
// - Taper end needs voltage near target, current in window, two 40 s ticks.
// - Termination sets terminate-charge and fully-charged, requests maintenance rate.
// - With sync on and low charge, termination loads capacity from percentage.
// - Fully-charged clears once relative charge drops below clear percentage.
// - Fast rate returns after fully-charged clears if voltage and temperature allow.
// - Terminate-charge from taper clears when not charging or taper lost.
// - Current over request plus margin zeroes request, sets terminate-charge.
// - Average over fast plus margin faults charge FET until below 256 mA.
// - Average at or below negative overload faults discharge FET until above -256 mA.
// - Pack or cell overvoltage zeroes request, faults charge FET until both clear.
// - Overtemperature zeroes request, sets alarms, clears on hysteresis or 43 C.
// - Overcharge sets alarms, cleared by discharge of 2 mAh.
// - Below 0 C zero request; below cold threshold precharge with hysteresis.
// - Discharging below battery-low sets fully-discharged, clears at 20 percent.
// - Cell undervoltage sets terminate-discharge and discharge FET fault.
// - Capacity and runtime alarms follow their settings.
module csa_charge_status #(
  parameter int unsigned TAPER_CYCLES = int'(csa_pkg::TAPER_CYC)
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Avalon-MM slave
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Indications
  output logic irq_out,
  output logic charge_fet_fault_out,
  output logic discharge_fet_fault_out,
  output logic [15:0] charge_current_request_out
);

  function automatic logic signed [17:0] sg(input logic [15:0] x);
    sg = {{2{x[15]}}, x};
  endfunction

  function automatic logic signed [17:0] ug(input logic [15:0] x);
    ug = {2'b00, x};
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Bus slave, one wait state per access
  logic ack_q;
  logic ack_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [15:0] cfg_q [csa_pkg::NCFG];
  logic [15:0] cfg_d [csa_pkg::NCFG];
  logic [csa_pkg::NST-1:0] st_q;
  logic [csa_pkg::NST-1:0] irq_q;
  logic [csa_pkg::NST-1:0] irq_d;
  logic [csa_pkg::NST-1:0] mask_q;
  logic [csa_pkg::NST-1:0] mask_d;
  logic sync_q;
  logic sync_d;
  logic [15:0] rmld_q;
  logic rmld_v_q;
  logic [15:0] cc_q;
  logic [5:0] widx;
  logic wr_en;
  logic upd;
  logic [15:0] wval;
  logic [csa_pkg::NST-1:0] st_d;

  assign widx = avs_address_in[7:2];
  assign wr_en = avs_write_in & ack_q;
  assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_q;
  assign upd = wr_en && widx == csa_pkg::W_CTRL && avs_byteenable_in[0]
    && avs_writedata_in[csa_pkg::CTRL_UPD];

  always_comb
  begin
    ack_d = (avs_read_in | avs_write_in) & ~ack_q;
    rdata_d = rdata_q;
    wval = avs_writedata_in[15:0];
    cfg_d = cfg_q;
    mask_d = mask_q;
    sync_d = sync_q;
    // Event set wins over a same-cycle write-one clear
    irq_d = irq_q & ~(st_d & ~st_q);
    if (wr_en && widx == csa_pkg::W_IRQ && avs_byteenable_in[0])
    begin
      irq_d = irq_q & ~avs_writedata_in[csa_pkg::NST-1:0];
    end
    irq_d = irq_d | (st_d & ~st_q);
    if (avs_read_in && !ack_q)
    begin
      rdata_d = 32'h0000_0000;
      if (widx >= csa_pkg::W_CFG0
        && widx < csa_pkg::W_CFG0 + 6'(csa_pkg::NCFG))
      begin
        rdata_d[15:0] = cfg_q[widx - csa_pkg::W_CFG0];
      end
      else
      begin
        case (widx)
          csa_pkg::W_CTRL: rdata_d[csa_pkg::CTRL_SYNC] = sync_q;
          csa_pkg::W_STAT: rdata_d[csa_pkg::NST-1:0] = st_q;
          csa_pkg::W_IRQ: rdata_d[csa_pkg::NST-1:0] = irq_q;
          csa_pkg::W_MASK: rdata_d[csa_pkg::NST-1:0] = mask_q;
          csa_pkg::W_CCREQ: rdata_d[15:0] = cc_q;
          csa_pkg::W_RMLD: rdata_d[16:0] = {rmld_v_q, rmld_q};
          default: rdata_d = 32'h0000_0000;
        endcase
      end
    end
    if (wr_en && avs_byteenable_in[0])
    begin
      if (widx == csa_pkg::W_MASK)
      begin
        mask_d = avs_writedata_in[csa_pkg::NST-1:0];
      end
      if (widx == csa_pkg::W_CTRL)
      begin
        sync_d = avs_writedata_in[csa_pkg::CTRL_SYNC];
      end
    end
    if (wr_en && widx >= csa_pkg::W_CFG0
      && widx < csa_pkg::W_CFG0 + 6'(csa_pkg::NCFG))
    begin
      if (avs_byteenable_in[0])
      begin
        cfg_d[widx - csa_pkg::W_CFG0][7:0] = wval[7:0];
      end
      if (avs_byteenable_in[1])
      begin
        cfg_d[widx - csa_pkg::W_CFG0][15:8] = wval[15:8];
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      irq_q <= '0;
      mask_q <= '0;
      sync_q <= 1'b0;
      for (int i = 0; i < csa_pkg::NCFG; i++)
      begin
        cfg_q[i] <= (i == csa_pkg::C_LTFH) ? csa_pkg::LTFH_RST : 16'h0000;
      end
    end
    else
    begin
      ack_q <= ack_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
      mask_q <= mask_d;
      sync_q <= sync_d;
      cfg_q <= cfg_d;
    end
  end

  assign avs_readdata_out = rdata_q;
  assign irq_out = |(irq_q & mask_q);

  ////////////////////////////////////////////////////////////////////
  // Taper interval timer and qualification
  logic [31:0] tmr_q;
  logic [31:0] tmr_d;
  logic [1:0] tap_q;
  logic [1:0] tap_d;
  logic tick;
  logic taper_now;
  logic term_ev;
  logic fc_q;

  assign tick = tmr_q == TAPER_CYCLES - 1;
  assign taper_now = ug(cfg_q[csa_pkg::C_VOLT]) >= ug(cfg_q[csa_pkg::C_CHGV])
    - ug(cfg_q[csa_pkg::C_TAPQV])
    && sg(cfg_q[csa_pkg::C_CURR]) < sg(cfg_q[csa_pkg::C_TAPI])
    && sg(cfg_q[csa_pkg::C_CURR]) > sg(csa_pkg::TAPER_MIN_I);
  // Second consecutive qualified tick ends the charge
  assign term_ev = tick && taper_now && tap_q == 2'd1 && !fc_q;

  always_comb
  begin
    tmr_d = tick ? 32'h0000_0000 : tmr_q + 32'h0000_0001;
    tap_d = tap_q;
    if (tick)
    begin
      tap_d = !taper_now ? 2'd0 : (tap_q == 2'd2 ? 2'd2 : tap_q + 2'd1);
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      tmr_q <= 32'h0000_0000;
      tap_q <= 2'd0;
    end
    else
    begin
      tmr_q <= tmr_d;
      tap_q <= tap_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Condition flags, updated on a measurement update; taper end also sets fully-charged and terminate-charge
  logic oc_q, poc_q, ol_q, ov_q, ot_q, och_q, pre_q, ttca_q;
  logic fd_q, ud_q, rca_q, rta_q;
  logic oc_d, poc_d, ol_d, ov_d, ot_d, och_d, pre_d, ttca_d;
  logic fc_d, fd_d, ud_d, rca_d, rta_d;
  logic [15:0] rmld_d;
  logic rmld_v_d;
  logic [15:0] cc_d;
  csa_pkg::csa_rate_t rate;
  logic signed [17:0] volt, curr, avgi, temp;
  logic cell_ov, cell_ovr, cell_uv, cell_uvr;
  logic [31:0] prod;

  assign volt = ug(cfg_q[csa_pkg::C_VOLT]);
  assign curr = sg(cfg_q[csa_pkg::C_CURR]);
  assign avgi = sg(cfg_q[csa_pkg::C_AVGI]);
  assign temp = sg(cfg_q[csa_pkg::C_TEMP]);
  assign prod = cfg_q[csa_pkg::C_TPCT] * cfg_q[csa_pkg::C_FCC];

  always_comb
  begin
    cell_ov = 1'b0;
    cell_ovr = 1'b1;
    cell_uv = 1'b0;
    cell_uvr = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      cell_ov = cell_ov | cfg_q[csa_pkg::C_CELL+i] >= cfg_q[csa_pkg::C_CELLOV];
      cell_ovr = cell_ovr & cfg_q[csa_pkg::C_CELL+i] <= cfg_q[csa_pkg::C_CELLOVR];
      cell_uv = cell_uv | cfg_q[csa_pkg::C_CELL+i] <= cfg_q[csa_pkg::C_CELLUV];
      cell_uvr = cell_uvr & cfg_q[csa_pkg::C_CELL+i] >= cfg_q[csa_pkg::C_CELLUVR];
    end
  end

  always_comb
  begin
    {oc_d, poc_d, ol_d, ov_d, ot_d, och_d} = {oc_q, poc_q, ol_q, ov_q, ot_q, och_q};
    {pre_d, ttca_d, fc_d, fd_d, ud_d} = {pre_q, ttca_q, fc_q, fd_q, ud_q};
    {rca_d, rta_d} = {rca_q, rta_q};
    rmld_d = rmld_q;
    rmld_v_d = rmld_v_q;
    if (upd)
    begin
      if (curr >= sg(cc_q) + sg(cfg_q[csa_pkg::C_OCM]))
        oc_d = 1'b1;
      else if (curr < sg(cfg_q[csa_pkg::C_OCM]))
        oc_d = 1'b0;
      if (avgi >= sg(cfg_q[csa_pkg::C_FASTI]) + sg(cfg_q[csa_pkg::C_OCM]))
        poc_d = 1'b1;
      else if (avgi < sg(csa_pkg::AVG_CLR_I))
        poc_d = 1'b0;
      if (avgi <= -sg(cfg_q[csa_pkg::C_OLI]))
        ol_d = 1'b1;
      else if (avgi > -sg(csa_pkg::AVG_CLR_I))
        ol_d = 1'b0;
      if (volt >= ug(cfg_q[csa_pkg::C_CHGV]) + ug(cfg_q[csa_pkg::C_OVM]) || cell_ov)
        ov_d = 1'b1;
      else if (cell_ovr)
        ov_d = 1'b0;
      if (temp >= sg(cfg_q[csa_pkg::C_MAXT]))
        ot_d = 1'b1;
      else if (temp <= sg(cfg_q[csa_pkg::C_MAXT]) - sg(cfg_q[csa_pkg::C_THYS])
        || temp <= sg(csa_pkg::OT_FLOOR_T))
        ot_d = 1'b0;
      if (cfg_q[csa_pkg::C_OVCHG] >= cfg_q[csa_pkg::C_MAXOC] && fc_q)
        och_d = 1'b1;
      else if (curr < 0 && cfg_q[csa_pkg::C_DSGMAH] >= csa_pkg::DSG_CLR_MAH)
        och_d = 1'b0;
      if (temp < sg(cfg_q[csa_pkg::C_LTF]))
        pre_d = 1'b1;
      else if (temp >= sg(cfg_q[csa_pkg::C_LTF]) + sg(cfg_q[csa_pkg::C_LTFH]))
        pre_d = 1'b0;
      if (curr <= 0 || !taper_now)
        ttca_d = 1'b0;
      if (cfg_q[csa_pkg::C_RELATIVE_CHARGE_PCT] < cfg_q[csa_pkg::C_FCCLR])
        fc_d = 1'b0;
      if (curr < 0 && cfg_q[csa_pkg::C_RELATIVE_CHARGE_PCT] < cfg_q[csa_pkg::C_BLOW])
        fd_d = 1'b1;
      else if (cfg_q[csa_pkg::C_RELATIVE_CHARGE_PCT] >= csa_pkg::FD_CLR_PCT)
        fd_d = 1'b0;
      if (cell_uv)
        ud_d = 1'b1;
      else if (volt > ug(cfg_q[csa_pkg::C_TERMV]) && cell_uvr)
        ud_d = 1'b0;
      rca_d = cfg_q[csa_pkg::C_RM] < cfg_q[csa_pkg::C_RCA];
      rta_d = cfg_q[csa_pkg::C_AVG_TIME_TO_EMPTY] < cfg_q[csa_pkg::C_RTA];
    end
    if (term_ev)
    begin
      fc_d = 1'b1;
      ttca_d = 1'b1;
      if (sync_q && cfg_q[csa_pkg::C_RELATIVE_CHARGE_PCT] < cfg_q[csa_pkg::C_TPCT])
      begin
        rmld_d = 16'(prod / 32'(csa_pkg::PCT_FULL));
        rmld_v_d = 1'b1;
      end
    end
    // Faults and cold win; precharge before maintenance before fast
    if (oc_d || poc_d || ov_d || ot_d || temp < 0)
      rate = csa_pkg::CSA_ZERO;
    else if (pre_d)
      rate = csa_pkg::CSA_PRE;
    else if (fc_d)
      rate = csa_pkg::CSA_MAINT;
    else
      rate = csa_pkg::CSA_FAST;
    case (rate)
      csa_pkg::CSA_ZERO: cc_d = 16'h0000;
      csa_pkg::CSA_PRE: cc_d = cfg_q[csa_pkg::C_PREI];
      csa_pkg::CSA_MAINT: cc_d = cfg_q[csa_pkg::C_MAINTI];
      csa_pkg::CSA_FAST: cc_d = cfg_q[csa_pkg::C_FASTI];
      default: cc_d = 16'h0000;
    endcase
    st_d = '0;
    st_d[csa_pkg::S_TCA] = oc_d | poc_d | ot_d | och_d | ttca_d;
    st_d[csa_pkg::S_OTA] = ot_d;
    st_d[csa_pkg::S_OCA] = och_d;
    st_d[csa_pkg::S_TDA] = ud_d;
    st_d[csa_pkg::S_FC] = fc_d;
    st_d[csa_pkg::S_FD] = fd_d;
    st_d[csa_pkg::S_RCA] = rca_d;
    st_d[csa_pkg::S_RTA] = rta_d;
    st_d[csa_pkg::S_CFET] = poc_d | ov_d | ot_d;
    st_d[csa_pkg::S_DFET] = ol_d | ud_d;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      {oc_q, poc_q, ol_q, ov_q, ot_q, och_q} <= 6'h00;
      {pre_q, ttca_q, fc_q, fd_q, ud_q, rca_q, rta_q} <= 7'h00;
      rmld_q <= 16'h0000;
      rmld_v_q <= 1'b0;
      cc_q <= 16'h0000;
      st_q <= '0;
    end
    else
    begin
      {oc_q, poc_q, ol_q, ov_q, ot_q, och_q} <= {oc_d, poc_d, ol_d, ov_d, ot_d, och_d};
      {pre_q, ttca_q, fc_q, fd_q, ud_q} <= {pre_d, ttca_d, fc_d, fd_d, ud_d};
      {rca_q, rta_q} <= {rca_d, rta_d};
      rmld_q <= rmld_d;
      rmld_v_q <= rmld_v_d;
      cc_q <= cc_d;
      st_q <= st_d;
    end
  end

  assign charge_current_request_out = cc_q;
  assign charge_fet_fault_out = st_q[csa_pkg::S_CFET];
  assign discharge_fet_fault_out = st_q[csa_pkg::S_DFET];

  ////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_taper_end: assert property (term_ev |=> st_q[csa_pkg::S_FC]
    && st_q[csa_pkg::S_TCA]) else $error("termination flags missing");
  a_taper_two: assert property (tick && !taper_now |=> tap_q == 2'd0)
    else $error("taper count not restarted");
  a_oc_zero: assert property (upd && curr >= sg(cc_q)
    + sg(cfg_q[csa_pkg::C_OCM]) |=> cc_q == 16'h0000 && st_q[csa_pkg::S_TCA])
    else $error("overcurrent not acted on");
  a_poc_fet: assert property (upd && avgi >= sg(cfg_q[csa_pkg::C_FASTI])
    + sg(cfg_q[csa_pkg::C_OCM]) |=> charge_fet_fault_out && cc_q == 16'h0000)
    else $error("prolonged overcurrent not acted on");
  a_ol_fet: assert property (upd && avgi <= -sg(cfg_q[csa_pkg::C_OLI])
    |=> discharge_fet_fault_out) else $error("overload fault missing");
  a_ot_alarm: assert property (upd && temp >= sg(cfg_q[csa_pkg::C_MAXT])
    |=> st_q[csa_pkg::S_OTA] && charge_fet_fault_out && cc_q == 16'h0000)
    else $error("overtemperature not acted on");
  a_cold_zero: assert property (upd && temp < 0
    |=> cc_q == 16'h0000) else $error("cold charge request not zero");
  a_rca_follow: assert property (upd |=> st_q[csa_pkg::S_RCA]
    == ($past(cfg_q[csa_pkg::C_RM]) < $past(cfg_q[csa_pkg::C_RCA])))
    else $error("capacity alarm mismatch");
  a_flags_hold: assert property (!upd && !term_ev |=> $stable(st_q[7:0])
    || $past(st_q) != $past(st_q, 2)) else $error("flags changed without update");

endmodule
`default_nettype wire

/* File: tb/csa_host_model.sv */
// Host side model: Avalon-MM master that reaches the evaluator's registers.
// Assumes callers enter its tasks just after a rising clock edge.
`timescale 1ns/1ns
`default_nettype none
module csa_host_model (
  // Clock
  input wire logic clk_in,
  // Slave answer
  input wire logic waitrequest_in,
  input wire logic [31:0] readdata_in,
  // Master request
  output logic [7:0] address_out,
  output logic read_out,
  output logic write_out,
  output logic [31:0] writedata_out,
  output logic [3:0] byteenable_out
);
  initial
  begin
    address_out = 8'h00;
    read_out = 1'b0;
    write_out = 1'b0;
    writedata_out = 32'h0000_0000;
    byteenable_out = 4'hF;
  end
  ////////////////////////////////////////////////////////////////////
  // Request held until waitrequest is seen low; one idle edge after it
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    address_out <= a;
    writedata_out <= {16'h0000, d};
    write_out <= 1'b1;
    @(posedge clk_in);
    while (waitrequest_in !== 1'b0)
      @(posedge clk_in);
    write_out <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    address_out <= a;
    read_out <= 1'b1;
    @(posedge clk_in);
    while (waitrequest_in !== 1'b0)
      @(posedge clk_in);
    d = readdata_in;
    read_out <= 1'b0;
    @(posedge clk_in);
  endtask
endmodule
`default_nettype wire

/* File: tb/test_csa_charge_status.sv */
// Self-checking bench for the charge status and alarm evaluator.
// Assumes a short taper period; host model drives the register bus.
`timescale 1ns/1ns
`default_nettype none
module test_csa_charge_status;
  typedef struct packed
  {
    logic [5:0] idx;
    logic [15:0] val;
    logic [9:0] st;
    logic [15:0] req;
  } csa_row_t;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] addr;
  logic rd_en;
  logic wr_en;
  logic [31:0] wdata;
  logic [3:0] be;
  logic [31:0] rdata;
  logic wreq;
  logic irq;
  logic cfet;
  logic dfet;
  logic [15:0] req;
  logic sync = 1'b0;
  logic [31:0] rdat;
  int err_count = 0;
  int num_checks = 0;
  // Baseline: 25 C, cells 3750 mV, 75 percent, nothing tripped
  logic [15:0] base [38] = '{16'h3A98, 16'h0000, 16'h0000, 16'h00FA, 16'h0EA6, 16'h0EA6,
    16'h0EA6, 16'h0EA6, 16'h0BB8, 16'h0FA0, 16'h004B, 16'h0064, 16'h0000, 16'h0000,
    16'h41A0, 16'h0FA0, 16'h0064, 16'h00C8, 16'h0064, 16'h00C8, 16'h03E8, 16'h00C8,
    16'h10CC, 16'h1036, 16'h0258, 16'h0032, 16'h0064, 16'h001E, 16'h1F40, 16'h0AF0,
    16'h0BB8, 16'h2EE0, 16'h000A, 16'h005A, 16'h0064, 16'h012C, 16'h000A, 16'h012C};
  // Each row changes one input, then expects status and request
  csa_row_t rows [36] = '{
    '{6'h03, 16'h00FA, 10'h000, 16'h0FA0}, '{6'h08, 16'h00C8, 10'h040, 16'h0FA0},
    '{6'h08, 16'h0BB8, 10'h000, 16'h0FA0}, '{6'h0B, 16'h0005, 10'h080, 16'h0FA0},
    '{6'h0B, 16'h0064, 10'h000, 16'h0FA0}, '{6'h03, 16'h0258, 10'h103, 16'h0000},
    '{6'h03, 16'h0230, 10'h103, 16'h0000}, '{6'h03, 16'h0226, 10'h000, 16'h0FA0},
    '{6'h03, 16'h0032, 10'h000, 16'h00C8}, '{6'h03, 16'h0078, 10'h000, 16'h00C8},
    '{6'h03, 16'h0082, 10'h000, 16'h0FA0}, '{6'h03, 16'hFFF6, 10'h000, 16'h0000},
    '{6'h03, 16'h00FA, 10'h000, 16'h0FA0}, '{6'h06, 16'h10CC, 10'h100, 16'h0000},
    '{6'h06, 16'h1068, 10'h100, 16'h0000}, '{6'h06, 16'h0EA6, 10'h000, 16'h0FA0},
    '{6'h00, 16'h4268, 10'h100, 16'h0000}, '{6'h00, 16'h3A98, 10'h000, 16'h0FA0},
    '{6'h01, 16'h2710, 10'h001, 16'h0000}, '{6'h01, 16'h04B0, 10'h001, 16'h0000},
    '{6'h01, 16'h0000, 10'h000, 16'h0FA0}, '{6'h02, 16'h2710, 10'h101, 16'h0000},
    '{6'h02, 16'h0258, 10'h101, 16'h0000}, '{6'h02, 16'h0190, 10'h000, 16'h0FA0},
    '{6'h02, 16'hE0C0, 10'h200, 16'h0FA0}, '{6'h02, 16'hFDA8, 10'h200, 16'h0FA0},
    '{6'h02, 16'h0000, 10'h000, 16'h0FA0}, '{6'h04, 16'h0AF0, 10'h208, 16'h0FA0},
    '{6'h04, 16'h0B54, 10'h208, 16'h0FA0}, '{6'h04, 16'h0EA6, 10'h000, 16'h0FA0},
    '{6'h01, 16'hFF38, 10'h000, 16'h0FA0}, '{6'h0A, 16'h0005, 10'h020, 16'h0FA0},
    '{6'h0A, 16'h0013, 10'h020, 16'h0FA0}, '{6'h0A, 16'h0014, 10'h000, 16'h0FA0},
    '{6'h0A, 16'h004B, 10'h000, 16'h0FA0}, '{6'h01, 16'h0000, 10'h000, 16'h0FA0}};
  always #10 clk_in = ~clk_in;
  ////////////////////////////////////////////////////////////////////
  // Short taper period keeps the run under a thousand cycles
  csa_charge_status #(.TAPER_CYCLES(50)) i_dut (.clk_in(clk_in), .rst_in(rst_in),
    .avs_address_in(addr), .avs_read_in(rd_en), .avs_write_in(wr_en),
    .avs_writedata_in(wdata), .avs_byteenable_in(be), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wreq), .irq_out(irq), .charge_fet_fault_out(cfet),
    .discharge_fet_fault_out(dfet), .charge_current_request_out(req));
  csa_host_model i_host (.clk_in(clk_in), .waitrequest_in(wreq), .readdata_in(rdata),
    .address_out(addr), .read_out(rd_en), .write_out(wr_en), .writedata_out(wdata),
    .byteenable_out(be));
  ////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t value mismatch got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cfg(input logic [5:0] i, input logic [15:0] v);
    i_host.wr({i, 2'b00} + 8'h40, v);
  endtask
  task automatic upd();
    i_host.wr(8'h00, {14'h0000, 1'b1, sync});
  endtask
  task automatic step(input logic [5:0] i, input logic [15:0] v);
    cfg(i, v);
    upd();
  endtask
  task automatic chk_st(input logic [9:0] st);
    i_host.rd(8'h04, rdat);
    chk(rdat, {22'h00_0000, st});
    chk({30'h0000_0000, dfet, cfet}, {30'h0000_0000, st[9:8]});
  endtask
  task finish_test();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge clk_in);
    err_count++;
    finish_test();
  end
  initial
  begin
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    chk({irq, cfet, dfet, req}, 19'h0_0000);
    chk_st(10'h000);
    i_host.rd(8'hAC, rdat);
    chk(rdat, 32'h0000_001E);
    // Unmapped word: write ignored, reads zero
    i_host.wr(8'h20, 16'hFFFF);
    i_host.rd(8'h20, rdat);
    chk(rdat, 32'h0000_0000);
    for (int k = 0; k < 38; k++)
      cfg(k[5:0], base[k]);
    foreach (rows[n])
    begin
      step(rows[n].idx, rows[n].val);
      chk_st(rows[n].st);
      chk({16'h0000, req}, {16'h0000, rows[n].req});
    end
    // Taper window held across several periods; charge kept above clear level
    sync = 1'b1;
    cfg(6'h0A, 16'h005F);
    step(6'h00, 16'h416E);
    // Current at the floor never qualifies
    step(6'h01, 16'h002D);
    repeat (40) upd();
    chk_st(10'h000);
    step(6'h01, 16'h0064);
    repeat (40) upd();
    chk_st(10'h011);
    chk({16'h0000, req}, 32'h0000_0064);
    i_host.rd(8'h14, rdat);
    chk(rdat, 32'h0001_0FA0);
    step(6'h01, 16'h0000);
    chk_st(10'h010);
    step(6'h0C, 16'h012C);
    chk_st(10'h015);
    cfg(6'h0C, 16'h0000);
    cfg(6'h0D, 16'h0002);
    step(6'h01, 16'hFFEC);
    chk_st(10'h010);
    cfg(6'h0D, 16'h0000);
    step(6'h01, 16'h0000);
    step(6'h0A, 16'h0059);
    chk_st(10'h000);
    chk({16'h0000, req}, 32'h0000_0FA0);
    // Interrupt: latched on rise, masked, cleared by one
    i_host.wr(8'h08, 16'h03FF);
    step(6'h08, 16'h00C8);
    i_host.rd(8'h08, rdat);
    chk(rdat, 32'h0000_0040);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    i_host.wr(8'h0C, 16'h0040);
    chk({31'h0000_0000, irq}, 32'h0000_0001);
    i_host.wr(8'h08, 16'h0040);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    // Second reset in mid-run with a fault standing
    step(6'h03, 16'h0258);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    chk_st(10'h000);
    chk({16'h0000, req}, 32'h0000_0000);
    finish_test();
  end
endmodule
`default_nettype wire
